// >>> adaptive_boost_voltage_control.sv
// Adaptive boost voltage control: registers, target regulation, protection.
// Assumes comparator and dimming inputs are synchronous to clock_i and the
// stored configuration stays static while the converter runs.
module adaptive_boost_voltage_control (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Register access
  input wire boost_ctl_pkg::reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Stored configuration
  input wire boost_ctl_pkg::cfg_type cfg_i,
  // Driver comparators and dimming context
  input wire boost_ctl_pkg::comp_type comp_i,
  input wire logic overcurrent_i,
  // Power stage
  output logic converter_run_o,
  output logic switch_rate_o,
  output logic [6:0] target_o,
  output logic [7:0] ovp_limit_o,
  // Comparator levels in millivolts
  output logic [15:0] low_level_mv_o,
  output logic [15:0] mid_level_mv_o,
  output logic [15:0] high_level_mv_o,
  // Open-drain fault pin
  output logic fault_pin_o,
  output logic fault_pin_oe_o
);

  boost_ctl_pkg::state_type q;
  boost_ctl_pkg::state_type d;

  // Clamp a manual code to the legal range
  function automatic logic [4:0] clamp_code(input logic [4:0] code);
    clamp_code = (code > boost_ctl_pkg::VOLT_MAX_CODE) ?
                 boost_ctl_pkg::VOLT_MAX_CODE : code;
  endfunction : clamp_code

  // Manual code in quarter volts: 1 V is four quarters
  function automatic logic [6:0] code_to_quarters(input logic [4:0] code);
    code_to_quarters = {clamp_code(code), 2'b00};
  endfunction : code_to_quarters

  // Clamp a quarter-volt value to 38 V
  function automatic logic [6:0] clamp_quarters(input logic [6:0] v);
    clamp_quarters = (v > boost_ctl_pkg::QUARTER_MAX) ?
                     boost_ctl_pkg::QUARTER_MAX : v;
  endfunction : clamp_quarters

  // Lead time in cycles from the two-bit field
  function automatic logic [15:0] lead_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: lead_cycles = boost_ctl_pkg::LEAD0_CYCLES;
      2'h1: lead_cycles = boost_ctl_pkg::LEAD1_CYCLES;
      2'h2: lead_cycles = boost_ctl_pkg::LEAD2_CYCLES;
      2'h3: lead_cycles = boost_ctl_pkg::LEAD3_CYCLES;
    endcase
  endfunction : lead_cycles

  logic [boost_ctl_pkg::STRINGS-1:0] low_hit;
  logic [boost_ctl_pkg::STRINGS-1:0] mid_ok;

  // Only conducting strings take part in the decisions
  genvar gi;
  generate
    for (gi = 0; gi < boost_ctl_pkg::STRINGS; gi++) begin : g_str
      assign low_hit[gi] = comp_i.active[gi] & comp_i.below_low[gi];
      assign mid_ok[gi] = ~comp_i.active[gi] | comp_i.above_mid[gi];
    end
  endgenerate

  logic any_low;
  logic all_mid;
  logic any_mid;
  logic lower_req;
  logic per_phase;
  logic ctl_write;
  logic status_read;
  logic [6:0] next_stored;

  // Raise on any low; lower on all above mid, or one in staggered low dimming
  assign any_low = |low_hit;
  assign all_mid = (|comp_i.active) & (&mid_ok);
  assign any_mid = |(comp_i.active & comp_i.above_mid);
  assign lower_req = (comp_i.staggered_dimming & comp_i.low_dimming) ?
                     any_mid : all_mid;
  // Per-phase tracking except when disabled or in the fastest stagger mode
  assign per_phase = comp_i.staggered_dimming & ~cfg_i.per_phase_adjust_off &
                     ~comp_i.fast_stagger;
  assign ctl_write = reg_req_i.wr &&
                     reg_req_i.addr == boost_ctl_pkg::ADDR_CONTROL;
  assign status_read = reg_req_i.rd &&
                       reg_req_i.addr == boost_ctl_pkg::ADDR_STATUS;
  assign next_stored = q.settled[comp_i.next_phase];

  // Next state
  always_comb begin
    d = q;
    d.fault_level = 1'b0;

    // Register writes
    if (reg_req_i.wr && reg_req_i.addr == boost_ctl_pkg::ADDR_VOLTAGE) begin
      d.voltage = clamp_code(reg_req_i.wdata[4:0]);
    end
    if (ctl_write) begin
      d.ctl = reg_req_i.wdata[2:0];
    end

    // Faults clear on run bit refresh or status read; a new event wins
    if ((ctl_write && reg_req_i.wdata[boost_ctl_pkg::CTL_RUN_BIT]) ||
        status_read) begin
      d.status = boost_ctl_pkg::STATUS_RESET;
    end
    if (overcurrent_i) begin
      d.status[boost_ctl_pkg::ST_OC_BIT] = 1'b1;
    end

    // Read data, registered one cycle after the read strobe
    d.rdata = 8'h00;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        boost_ctl_pkg::ADDR_VOLTAGE: d.rdata = {3'h0, q.voltage};
        boost_ctl_pkg::ADDR_CONTROL: d.rdata = {5'h00, q.ctl};
        boost_ctl_pkg::ADDR_STATUS: d.rdata = {6'h00, q.status};
        default: d.rdata = 8'h00;
      endcase
    end

    // Run state and target
    unique case (q.mode)
      boost_ctl_pkg::MODE_OFF: begin
        d.step_cnt = 8'h00;
        if (q.ctl[boost_ctl_pkg::CTL_ON_BIT] && q.status == 2'h0 &&
            !overcurrent_i) begin
          d.mode = boost_ctl_pkg::MODE_RUN;
          if (q.ctl[boost_ctl_pkg::CTL_AUTO_BIT]) begin
            d.target = clamp_quarters(cfg_i.start_target);
          end else begin
            d.target = code_to_quarters(q.voltage);
          end
          for (int i = 0; i < boost_ctl_pkg::STRINGS; i++) begin
            d.settled[i] = d.target;
          end
        end
      end
      boost_ctl_pkg::MODE_RUN: begin
        if (!q.ctl[boost_ctl_pkg::CTL_ON_BIT] || overcurrent_i ||
            q.status[boost_ctl_pkg::ST_OC_BIT]) begin
          d.mode = boost_ctl_pkg::MODE_OFF;
        end else if (!q.ctl[boost_ctl_pkg::CTL_AUTO_BIT]) begin
          d.target = code_to_quarters(q.voltage);
          d.step_cnt = 8'h00;
        end else if (ctl_write && reg_req_i.wdata[boost_ctl_pkg::CTL_AUTO_BIT]
                     && !q.ctl[boost_ctl_pkg::CTL_AUTO_BIT]) begin
          d.target = code_to_quarters(q.voltage);
        end else if (per_phase && comp_i.phase_step) begin
          // Keep this string's settled value, move to the next one's
          d.settled[q.phase] = q.target;
          d.phase = comp_i.next_phase;
          d.target = next_stored;
          d.step_cnt = 8'h00;
        end else if (per_phase && next_stored > q.target &&
                     comp_i.cycles_to_step == lead_cycles(cfg_i.lead_time))
                     begin
          d.target = next_stored;
        end else if (q.step_cnt == 8'(boost_ctl_pkg::STEP_CYCLES - 1)) begin
          d.step_cnt = 8'h00;
          if (any_low && q.target < boost_ctl_pkg::QUARTER_MAX) begin
            d.target = q.target + 7'h01;
          end else if (lower_req && q.target != 7'h00) begin
            d.target = q.target - 7'h01;
          end
        end else begin
          d.step_cnt = q.step_cnt + 8'h01;
        end
      end
    endcase

    // Auto headroom turned on after start uses the manual register
    if (q.mode == boost_ctl_pkg::MODE_RUN && ctl_write &&
        reg_req_i.wdata[boost_ctl_pkg::CTL_AUTO_BIT] &&
        !q.ctl[boost_ctl_pkg::CTL_AUTO_BIT]) begin
      d.target = code_to_quarters(q.voltage);
    end

    // Outputs to the power stage and the fault pin
    d.running = d.mode == boost_ctl_pkg::MODE_RUN;
    d.rate = cfg_i.switch_rate_select;
    d.ovp_limit = {1'b0, d.target} + boost_ctl_pkg::OVP_MARGIN;
    d.fault_oe = d.status != 2'h0;

    // Comparator levels
    d.low_mv = boost_ctl_pkg::LOW_BASE_MV +
               16'(16'(cfg_i.lower_compare_level) *
                   boost_ctl_pkg::LOW_STEP_MV);
    d.mid_mv = d.low_mv + boost_ctl_pkg::MID_OFFSET_MV;
    d.high_mv = boost_ctl_pkg::HIGH_BASE_MV +
                16'(16'(cfg_i.upper_compare_level) *
                    boost_ctl_pkg::HIGH_STEP_MV);
  end

  // State register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q.mode <= boost_ctl_pkg::MODE_OFF;
      q.voltage <= boost_ctl_pkg::VOLT_RESET;
      q.ctl <= boost_ctl_pkg::CTL_RESET;
      q.status <= boost_ctl_pkg::STATUS_RESET;
      q.rdata <= 8'h00;
      q.target <= boost_ctl_pkg::TARGET_RESET;
      q.ovp_limit <= boost_ctl_pkg::OVP_MARGIN;
      q.settled <= '0;
      q.phase <= 3'h0;
      q.step_cnt <= 8'h00;
      q.running <= 1'b0;
      q.rate <= 1'b0;
      q.fault_oe <= 1'b0;
      q.fault_level <= 1'b0;
      q.low_mv <= boost_ctl_pkg::LOW_BASE_MV;
      q.mid_mv <= boost_ctl_pkg::LOW_BASE_MV + boost_ctl_pkg::MID_OFFSET_MV;
      q.high_mv <= boost_ctl_pkg::HIGH_BASE_MV;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign converter_run_o = q.running;
  assign switch_rate_o = q.rate;
  assign target_o = q.target;
  assign ovp_limit_o = q.ovp_limit;
  assign low_level_mv_o = q.low_mv;
  assign mid_level_mv_o = q.mid_mv;
  assign high_level_mv_o = q.high_mv;
  assign fault_pin_o = q.fault_level;
  assign fault_pin_oe_o = q.fault_oe;

endmodule : adaptive_boost_voltage_control

// >>> boost_ctl_pkg.sv
// Constants, types and register layout of the adaptive boost voltage control.
// Assumes one 200 MHz clock and stored configuration driven as static inputs.
// Notes on behaviour
// - Manual mode: 5-bit code, 10 V at zero, 1 V per step, 38 V at 28.
// - Manual voltage register at 07H sets the target while auto headroom is off and seeds it when auto turns on.
// - One stored bit selects 625 kHz or 1.25 MHz switching.
// - Converter runs only while the converter on bit is set.
// - Adaptive mode moves the target in 0.25 V steps.
// - Auto headroom bit selects adaptive mode; adaptive is the reset default.
// - Starting with adaptive on takes the first target from stored byte 29H.
// - Adaptive turned on while running starts from the 07H register value.
// - Staggered dimming adjusts per phase unless disabled or at 19.5 kHz.
// - Settled voltage of each string is stored and used to raise early.
// - Lead time before a phase step comes from a two-bit stored field.
// - Simultaneous strings regulate for the highest forward voltage among them.
// - Drivers compare to low, mid and high; mid sits 0.5 V above low.
// - Low level 0.50 V plus 0.25 V per code; high 3 V plus 1 V.
// - A lone conducting string is held between low and mid thresholds.
// - Any active driver below low raises the target.
// - All active above mid lowers; staggered low dimming needs only one.
// - Decisions use only the strings conducting at that moment.
// - Overvoltage limit follows the current target setting.
// - Overcurrent sets the fault flag and shuts the converter down.
// - Any fault pulls the fault pin low and records its cause in status.
// - Writing the backlight run bit high clears faults and releases the pin.
// - Reading the status register clears latched faults.
package boost_ctl_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_VOLTAGE = 8'h07;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h09;

  // Control register fields and reset value (auto headroom set)
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_AUTO_BIT = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam logic [2:0] CTL_RESET = 3'h2;

  // Status register fields
  localparam int ST_OC_BIT = 0;
  localparam logic [1:0] STATUS_RESET = 2'h0;

  // Manual voltage code
  localparam logic [4:0] VOLT_RESET = 5'h00;
  localparam logic [4:0] VOLT_MAX_CODE = 5'h1C;

  // Target in quarter volts above 10 V; 112 quarters is 38 V
  localparam logic [6:0] QUARTER_MAX = 7'h70;
  localparam logic [6:0] TARGET_RESET = 7'h00;
  localparam logic [7:0] OVP_MARGIN = 8'h08;

  localparam int STRINGS = 7;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD0_NS = 2000;
  localparam int LEAD1_NS = 4000;
  localparam int LEAD2_NS = 8000;
  localparam int LEAD3_NS = 16000;
  localparam logic [15:0] LEAD0_CYCLES = 16'(LEAD0_NS / CLK_PERIOD_NS);
  localparam logic [15:0] LEAD1_CYCLES = 16'(LEAD1_NS / CLK_PERIOD_NS);
  localparam logic [15:0] LEAD2_CYCLES = 16'(LEAD2_NS / CLK_PERIOD_NS);
  localparam logic [15:0] LEAD3_CYCLES = 16'(LEAD3_NS / CLK_PERIOD_NS);

  // Comparator threshold decode in millivolts
  localparam logic [15:0] LOW_BASE_MV = 16'h01F4;
  localparam logic [15:0] LOW_STEP_MV = 16'h00FA;
  localparam logic [15:0] MID_OFFSET_MV = 16'h01F4;
  localparam logic [15:0] HIGH_BASE_MV = 16'h0BB8;
  localparam logic [15:0] HIGH_STEP_MV = 16'h03E8;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b01,
    MODE_RUN = 2'b10
  } run_mode_type;

  // Register access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Stored configuration
  typedef struct packed {
    logic switch_rate_select;
    logic per_phase_adjust_off;
    logic [1:0] lead_time;
    logic [2:0] lower_compare_level;
    logic [2:0] upper_compare_level;
    logic [6:0] start_target;
  } cfg_type;

  // Driver comparators and dimming context
  typedef struct packed {
    logic [STRINGS-1:0] active;
    logic [STRINGS-1:0] below_low;
    logic [STRINGS-1:0] above_mid;
    logic staggered_dimming;
    logic fast_stagger;
    logic low_dimming;
    logic phase_step;
    logic [2:0] next_phase;
    logic [15:0] cycles_to_step;
  } comp_type;

  // Whole module state
  typedef struct packed {
    run_mode_type mode;
    logic [4:0] voltage;
    logic [2:0] ctl;
    logic [1:0] status;
    logic [7:0] rdata;
    logic [6:0] target;
    logic [7:0] ovp_limit;
    logic [STRINGS-1:0][6:0] settled;
    logic [2:0] phase;
    logic [7:0] step_cnt;
    logic running;
    logic rate;
    logic fault_oe;
    logic fault_level;
    logic [15:0] low_mv;
    logic [15:0] mid_mv;
    logic [15:0] high_mv;
  } state_type;

endpackage : boost_ctl_pkg

// >>> boost_ctl_checker.sv
// Port-level checks for the adaptive boost voltage control.
// Assumes one clock domain and the register offsets of the package.
module boost_ctl_checker (
  // Clock, reset and inputs
  input wire logic clock_i,
  input wire logic reset_i,
  input wire boost_ctl_pkg::reg_req_type reg_req_i,
  input wire boost_ctl_pkg::cfg_type cfg_i,
  input wire logic overcurrent_i,
  // Outputs
  input wire logic converter_run_o,
  input wire logic switch_rate_o,
  input wire logic [6:0] target_o,
  input wire logic [7:0] ovp_limit_o,
  input wire logic [15:0] low_level_mv_o,
  input wire logic [15:0] mid_level_mv_o,
  input wire logic [15:0] high_level_mv_o,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe_o
);
  logic auto_q;
  logic on_q;
  logic [4:0] code_q;
  logic [1:0] quiet_q;
  logic wr_ctl;
  assign wr_ctl = reg_req_i.wr &&
                  reg_req_i.addr == boost_ctl_pkg::ADDR_CONTROL;
  // Shadow of control and voltage writes, and cycles since a write
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      auto_q <= 1'b1;
      on_q <= 1'b0;
      code_q <= 5'h00;
      quiet_q <= 2'h0;
    end else begin
      quiet_q <= reg_req_i.wr ? 2'h0 :
                 (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
      if (wr_ctl) begin
        auto_q <= reg_req_i.wdata[1];
        on_q <= reg_req_i.wdata[0];
      end
      if (reg_req_i.wr && reg_req_i.addr == boost_ctl_pkg::ADDR_VOLTAGE) begin
        code_q <= reg_req_i.wdata > 8'h1C ? 5'h1C : reg_req_i.wdata[4:0];
      end
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence status_read_s;
    reg_req_i.rd && reg_req_i.addr == boost_ctl_pkg::ADDR_STATUS
      && !overcurrent_i ##1 !overcurrent_i;
  endsequence
  sequence run_write_s;
    wr_ctl && reg_req_i.wdata[2] && !overcurrent_i ##1 !overcurrent_i;
  endsequence
  ovp_track_a: assert property (
    $stable(target_o) |-> ovp_limit_o == {1'b0, target_o} + 8'h08)
    else $error("ovp limit off target");
  low_decode_a: assert property (
    !$past(reset_i) |-> low_level_mv_o ==
      16'h01F4 + 16'h00FA * $past(cfg_i.lower_compare_level))
    else $error("low level decode wrong");
  mid_offset_a: assert property (
    mid_level_mv_o == low_level_mv_o + 16'h01F4)
    else $error("mid level not low plus 500");
  high_decode_a: assert property (
    !$past(reset_i) |-> high_level_mv_o ==
      16'h0BB8 + 16'h03E8 * $past(cfg_i.upper_compare_level))
    else $error("high level decode wrong");
  rate_copy_a: assert property (
    !$past(reset_i) |-> switch_rate_o == $past(cfg_i.switch_rate_select))
    else $error("rate select not followed");
  run_needs_on_a: assert property (
    !on_q && quiet_q == 2'h3 |-> !converter_run_o)
    else $error("running with on bit clear");
  manual_target_a: assert property (
    converter_run_o && !auto_q && quiet_q == 2'h3 |->
      target_o == {code_q, 2'b00})
    else $error("manual target not code times four");
  oc_shutdown_a: assert property (
    overcurrent_i |=> !converter_run_o)
    else $error("run kept after overcurrent");
  oc_flag_a: assert property (
    overcurrent_i |-> ##[1:3] fault_pin_oe_o)
    else $error("fault pin not pulled");
  pin_low_a: assert property (
    fault_pin_oe_o |-> !fault_pin_o)
    else $error("fault pin driven high");
  read_clear_a: assert property (
    status_read_s |=> !fault_pin_oe_o)
    else $error("status read left fault");
  run_clear_a: assert property (
    run_write_s |=> !fault_pin_oe_o)
    else $error("run bit write left fault");
endmodule : boost_ctl_checker

bind adaptive_boost_voltage_control boost_ctl_checker boost_ctl_checker_inst (
  .clock_i(clock_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
  .cfg_i(cfg_i), .overcurrent_i(overcurrent_i),
  .converter_run_o(converter_run_o), .switch_rate_o(switch_rate_o),
  .target_o(target_o), .ovp_limit_o(ovp_limit_o),
  .low_level_mv_o(low_level_mv_o), .mid_level_mv_o(mid_level_mv_o),
  .high_level_mv_o(high_level_mv_o), .fault_pin_o(fault_pin_o),
  .fault_pin_oe_o(fault_pin_oe_o));

// >>> boost_stage_model.sv
// Behavioural power stage and driver comparators.
// Assumes string i needs need_i + i quarter volts of target.
module boost_stage_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Stage control and load
  input wire logic run_i,
  input wire logic [6:0] target_i,
  input wire logic [6:0] need_i,
  input wire logic [6:0] active_i,
  // Dimming context: bit 0 staggered, bit 1 low dimming value
  input wire logic [1:0] dim_i,
  // Comparators
  output boost_ctl_pkg::comp_type comp_o
);
  logic [9:0] tick_q;
  // Phase step timer, one step every 1000 cycles
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) tick_q <= 10'h000;
    else tick_q <= tick_q == 10'h3E7 ? 10'h000 : tick_q + 10'h001;
  end
  // Only conducting strings report; each has its own forward voltage
  always_comb begin
    comp_o = '0;
    comp_o.active = run_i ? active_i : 7'h00;
    comp_o.staggered_dimming = dim_i[0];
    comp_o.low_dimming = dim_i[1];
    for (int i = 0; i < 7; i++) begin
      comp_o.below_low[i] = comp_o.active[i] &&
                            target_i < need_i + 7'(i);
      comp_o.above_mid[i] = comp_o.active[i] &&
                            target_i > need_i + 7'(i + 2);
    end
    comp_o.phase_step = tick_q == 10'h3E7;
    comp_o.cycles_to_step = 16'(10'h3E7 - tick_q);
  end
endmodule : boost_stage_model

// >>> tb_adaptive_boost_voltage_control.sv
// Self-checking bench for the adaptive boost voltage control.
// Assumes the stage model drives the comparators from the live target.
module tb_adaptive_boost_voltage_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_i, oc, run, rate, pin, oe;
  boost_ctl_pkg::reg_req_type req;
  boost_ctl_pkg::cfg_type cfg;
  boost_ctl_pkg::comp_type comp;
  logic [7:0] rdata, ovp, d, v;
  logic [6:0] target, need, act;
  logic [1:0] dim;
  logic [15:0] lo, mi, hi;
  logic [31:0] seed;
  int error_cnt, total_checks;
  adaptive_boost_voltage_control adaptive_boost_voltage_control_inst (
    .clock_i(clock_i), .reset_i(reset_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .cfg_i(cfg), .comp_i(comp), .overcurrent_i(oc),
    .converter_run_o(run), .switch_rate_o(rate), .target_o(target),
    .ovp_limit_o(ovp), .low_level_mv_o(lo), .mid_level_mv_o(mi),
    .high_level_mv_o(hi), .fault_pin_o(pin), .fault_pin_oe_o(oe));
  boost_stage_model boost_stage_model_inst (
    .clock_i(clock_i), .reset_i(reset_i), .run_i(run), .target_i(target),
    .need_i(need), .active_i(act), .dim_i(dim), .comp_o(comp));
  // Clock, 5 ns period
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Expectation and random helpers
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function logic [7:0] code_q4(input logic [7:0] c);
    return (c > 8'h1C ? 8'h1C : c) * 8'h04;
  endfunction : code_q4
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clock_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 r = rdata;
  endtask : rd
  task wait_move(input logic [6:0] dlt);
    logic [6:0] t0;
    t0 = target;
    for (int k = 0; k < 400 && target === t0; k++) cyc(1);
    chk("target", 16'(7'(t0 + dlt)), 16'(target));
  endtask : wait_move
  task final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    final_report();
  end
  // Main sequence
  initial begin
    seed = 32'h0000000C;
    req = '0;
    oc = 1'b0;
    need = 7'h00;
    act = 7'h7F;
    dim = 2'h0;
    cfg = '0;
    cfg.per_phase_adjust_off = 1'b1;
    reset_i = 1'b1;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(8'h08, d); chk("ctl", 16'h0002, 16'(d));
    wr(8'h0A, 8'hFF);
    rd(8'h0A, d); chk("unmapped", 16'h0000, 16'(d));
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      cfg.lower_compare_level <= 3'(i);
      cfg.upper_compare_level <= 3'(7 - i);
      cfg.switch_rate_select <= i[0];
      cyc(3);
      chk("low", 16'h01F4 + 16'h00FA * 16'(i), lo);
      chk("mid", 16'h03E8 + 16'h00FA * 16'(i), mi);
      chk("high", 16'h0BB8 + 16'h03E8 * 16'(7 - i), hi);
      chk("rate", 16'(i[0]), 16'(rate));
    end
    wr(8'h08, 8'h01);
    cyc(3);
    chk("run", 16'h0001, 16'(run));
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = i == 0 ? 8'h00 : i == 1 ? 8'h1C : i == 2 ? 8'h1F : 8'(seed % 29);
      wr(8'h07, d);
      cyc(3);
      rd(8'h07, v); chk("code", 16'(code_q4(d) >> 2), 16'(v));
      chk("target", 16'(code_q4(d)), 16'(target));
      chk("ovp", 16'(code_q4(d) + 8'h08), 16'(ovp));
    end
    wr(8'h07, 8'h0A);
    @(posedge clock_i);
    need <= 7'h3C;
    wr(8'h08, 8'h03);
    wait_move(7'h01);
    @(posedge clock_i);
    need <= target - 7'h05;
    act <= 7'h41;
    wait_move(7'h01);
    // Staggered low dimming: one string above mid is enough to lower
    @(posedge clock_i);
    dim <= 2'h3;
    wait_move(7'h7F);
    @(posedge clock_i);
    dim <= 2'h0;
    act <= 7'h01;
    wait_move(7'h7F);
    wr(8'h08, 8'h00);
    seed = xs(seed);
    @(posedge clock_i);
    cfg.start_target <= 7'(seed % 112 + 1);
    need <= 7'(seed % 112);
    wr(8'h08, 8'h03);
    cyc(3);
    chk("start", 16'(seed % 112 + 1), 16'(target));
    @(posedge clock_i);
    oc <= 1'b1;
    @(posedge clock_i);
    oc <= 1'b0;
    cyc(3);
    chk("run", 16'h0000, 16'(run));
    chk("pin", 16'h0001, 16'(oe & ~pin));
    rd(8'h09, d); chk("status", 16'h0001, 16'(d));
    rd(8'h09, d); chk("status", 16'h0000, 16'(d));
    cyc(2);
    chk("pin", 16'h0000, 16'(oe));
    @(posedge clock_i);
    oc <= 1'b1;
    @(posedge clock_i);
    oc <= 1'b0;
    wr(8'h08, 8'h07);
    cyc(3);
    chk("pin", 16'h0000, 16'(oe));
    rd(8'h09, d); chk("status", 16'h0000, 16'(d));
    chk("run", 16'h0001, 16'(run));
    final_report();
  end
endmodule : tb_adaptive_boost_voltage_control
